// file: hdl/scrf_ondelay.sv
// on-delay timer counting scan ticks while enabled
`timescale 1ns/100ps
module scrf_ondelay #(
   parameter logic [scrf_pkg::TMR_W-1:0] PRESET = scrf_pkg::DELAY_A_TICKS
) (
   input  wire logic                        clk_in,    // controller clock
   input  wire logic                        arst_n_in, // async reset
   input  wire logic                        tick_in,   // time-base tick
   input  wire logic                        enable_in, // trigger coil
   output wire logic                        done_out,  // timer contact
   output logic      [scrf_pkg::TMR_W-1:0]  count_out  // elapsed ticks
);
   import scrf_pkg::*;

   // elapsed time is cleared on the first tick after the trigger drops
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         count_out <= TMR_ZERO;
      end else if (tick_in) begin
         if (!enable_in) begin
            count_out <= TMR_ZERO;
         end else if (count_out != PRESET) begin
            count_out <= count_out + 1'b1;
         end
      end
   end

   assign done_out = enable_in && (count_out == PRESET);

endmodule : scrf_ondelay

// file: hdl/scrf_pkg.sv
// shared constants and carrier types of the scan-cycle relay block
package scrf_pkg;

   // ****************************************
   // clock and scan timing
   // ****************************************
   localparam int CLK_PERIOD_NS  = 10;
   localparam int SCAN_PERIOD_MS = 10;
   localparam int NS_PER_MS      = 1_000_000;
   localparam int SCAN_DIV       = SCAN_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int SCAN_CNT_W     = 20;
   localparam int TICKS_PER_S    = 1000 / SCAN_PERIOD_MS;

   // ****************************************
   // timer presets, counted in scan ticks
   // ****************************************
   localparam int DELAY_A_S    = 10;
   localparam int HOLD_S       = 2;
   localparam int AUTO_OFF_MIN = 6;
   localparam int LONG_OFF_H   = 4;
   localparam int FLASH_S      = 1;
   localparam int TMR_W        = 21;
   localparam logic [TMR_W-1:0] TMR_ZERO = 21'h0;
   localparam logic [TMR_W-1:0] DELAY_A_TICKS =
      TMR_W'(DELAY_A_S * TICKS_PER_S);
   localparam logic [TMR_W-1:0] HOLD_TICKS = TMR_W'(HOLD_S * TICKS_PER_S);
   localparam logic [TMR_W-1:0] AUTO_OFF_TICKS =
      TMR_W'(AUTO_OFF_MIN * 60 * TICKS_PER_S);
   localparam logic [TMR_W-1:0] LONG_OFF_TICKS =
      TMR_W'(LONG_OFF_H * 3600 * TICKS_PER_S);
   // flasher restarts itself: two scans go to done and re-arm
   localparam logic [TMR_W-1:0] FLASH_PRESET =
      TMR_W'(FLASH_S * TICKS_PER_S - 2);

   // ****************************************
   // counter and storage
   // ****************************************
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] CNT_ZERO   = 5'h00;
   localparam logic [CNT_W-1:0] CNT_PRESET = 5'h14;
   localparam int STORE_N = 4;
   localparam logic [STORE_N-1:0] STORE_ZERO = 4'h0;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic toggle_btn;
      logic timer_trigger;
      logic count_btn;
      logic counter_clear;
      logic shift_btn;
      logic shift_value;
      logic shift_clear;
      logic run_mode;
      logic stair_btn;
      logic stair_enhanced;
   } scrf_pins_t;

   typedef struct packed {
      logic               toggle_relay;
      logic               delay_relay;
      logic               count_relay;
      logic [STORE_N-1:0] store;
      logic [STORE_N-1:0] run_light;
      logic               stair_light;
   } scrf_relays_t;

   localparam scrf_pins_t   PINS_RST   = 10'h000;
   localparam scrf_relays_t RELAYS_RST = 12'h000;

endpackage : scrf_pkg

// file: hdl/scrf_top.sv
// scan-cycle relay functions: toggle, timers, counter, shift chains, stairs
`timescale 1ns/100ps
module scrf_top #(
   parameter int                         SCAN_DIV_P = scrf_pkg::SCAN_DIV,
   parameter logic [scrf_pkg::TMR_W-1:0] AUTO_OFF_P =
      scrf_pkg::AUTO_OFF_TICKS,
   parameter logic [scrf_pkg::TMR_W-1:0] LONG_OFF_P =
      scrf_pkg::LONG_OFF_TICKS
) (
   input  wire logic                   CLK_IN,     // 100 MHz clock
   input  wire logic                   ARST_N_IN,  // async reset, low
   input  wire scrf_pkg::scrf_pins_t   PINS_IN,    // button pins
   output scrf_pkg::scrf_relays_t      RELAYS_OUT  // relay drives
);
   import scrf_pkg::*;

   // ****************************************
   // declarations
   // ****************************************
   scrf_pins_t               pin_s1;
   scrf_pins_t               pin_s2;
   scrf_pins_t               img;
   scrf_relays_t             rel;
   logic [SCAN_CNT_W-1:0]    scan_cnt;
   logic                     tgl_prev;
   logic                     cnt_prev;
   logic [CNT_W-1:0]         cnt;
   logic                     edge_c;
   logic                     shot_c;
   logic                     flash_c;
   logic                     rl_edge_c;
   logic                     rl_shot_c;
   logic                     seed_c;
   logic                     st_prev;
   logic                     cont_c;
   logic [TMR_W-1:0]         dly_cnt;
   logic                     dly_done;
   logic                     flash_done;
   logic                     hold_done;
   logic                     auto_done;
   logic                     long_done;
   logic [STORE_N-1:0]       next_store;
   logic [STORE_N-1:0]       next_run;

   // ****************************************
   // pin synchronisers
   // ****************************************
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         pin_s1 <= PINS_RST;
         pin_s2 <= PINS_RST;
      end else begin
         pin_s1 <= PINS_IN;
         pin_s2 <= pin_s1;
      end
   end

   // ****************************************
   // scan tick, also the common time base
   // ****************************************
   wire scan_tick = (scan_cnt == SCAN_CNT_W'(SCAN_DIV_P - 1));

   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         scan_cnt <= {SCAN_CNT_W{1'b0}};
      end else if (scan_tick) begin
         scan_cnt <= {SCAN_CNT_W{1'b0}};
      end else begin
         scan_cnt <= scan_cnt + 1'b1;
      end
   end

   // input image is frozen for a whole scan
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         img <= PINS_RST;
      end else if (scan_tick) begin
         img <= pin_s2;
      end
   end

   // ****************************************
   // timers
   // ****************************************
   scrf_ondelay #(.PRESET(DELAY_A_TICKS)) delay_timer_a (
      .clk_in    (CLK_IN),
      .arst_n_in (ARST_N_IN),
      .tick_in   (scan_tick),
      .enable_in (img.timer_trigger),
      .done_out  (dly_done),
      .count_out (dly_cnt)
   );

   scrf_ondelay #(.PRESET(FLASH_PRESET)) flasher_timer (
      .clk_in    (CLK_IN),
      .arst_n_in (ARST_N_IN),
      .tick_in   (scan_tick),
      .enable_in (img.run_mode && !flash_c),
      .done_out  (flash_done),
      .count_out ()
   );

   scrf_ondelay #(.PRESET(HOLD_TICKS)) hold_detect_timer (
      .clk_in    (CLK_IN),
      .arst_n_in (ARST_N_IN),
      .tick_in   (scan_tick),
      .enable_in (img.stair_btn),
      .done_out  (hold_done),
      .count_out ()
   );

   scrf_ondelay #(.PRESET(AUTO_OFF_P)) auto_off_timer (
      .clk_in    (CLK_IN),
      .arst_n_in (ARST_N_IN),
      .tick_in   (scan_tick),
      .enable_in (rel.stair_light && !cont_c),
      .done_out  (auto_done),
      .count_out ()
   );

   scrf_ondelay #(.PRESET(LONG_OFF_P)) long_off_timer (
      .clk_in    (CLK_IN),
      .arst_n_in (ARST_N_IN),
      .tick_in   (scan_tick),
      .enable_in (rel.stair_light && cont_c && img.stair_enhanced),
      .done_out  (long_done),
      .count_out ()
   );

   // ****************************************
   // rung decoding
   // ****************************************
   wire tgl_rise  = img.toggle_btn && !tgl_prev;
   wire cnt_rise  = img.count_btn && !cnt_prev;
   wire cnt_step  = cnt_rise && (cnt != CNT_PRESET);
   wire [CNT_W-1:0] next_cnt = img.counter_clear ? CNT_ZERO :
                               cnt_step ? cnt + 1'b1 : cnt;
   wire shot_coil = img.shift_btn && !edge_c;
   wire rl_shot   = flash_c && !rl_edge_c;
   wire run_value = !seed_c || rel.run_light[STORE_N-1];
   wire st_rise   = img.stair_btn && !st_prev;
   wire light_tgl = rel.stair_light ^ st_rise;
   wire light_on  = hold_done ? 1'b1 : light_tgl;
   wire next_light = (auto_done || long_done) ? 1'b0 : light_on;
   wire next_cont = next_light && (cont_c || hold_done);

   // first positions take the shift input value and the seed or wrapped last light
   assign next_store[0] = img.shift_clear ? 1'b0 :
                          shot_c ? img.shift_value : rel.store[0];
   assign next_run[0]   = !img.run_mode ? 1'b0 :
                          rl_shot_c ? run_value : rel.run_light[0];

   // each later position takes its predecessor's old value
   generate
      for (genvar i = 1; i < STORE_N; i++) begin : g_chain
         assign next_store[i] = img.shift_clear ? 1'b0 :
                                shot_c ? rel.store[i-1] :
                                rel.store[i];
         assign next_run[i]   = !img.run_mode ? 1'b0 :
                                rl_shot_c ? rel.run_light[i-1] :
                                rel.run_light[i];
      end
   endgenerate

   // ****************************************
   // scan transfer of coils to contacts
   // ****************************************
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         tgl_prev  <= 1'b0;
         cnt_prev  <= 1'b0;
         cnt       <= CNT_ZERO;
         edge_c    <= 1'b0;
         shot_c    <= 1'b0;
         st_prev   <= 1'b0;
         cont_c    <= 1'b0;
      end else if (scan_tick) begin
         tgl_prev  <= img.toggle_btn;
         cnt_prev  <= img.count_btn;
         cnt       <= next_cnt;
         edge_c    <= img.shift_btn;
         shot_c    <= shot_coil;
         st_prev   <= img.stair_btn;
         cont_c    <= next_cont;
      end
   end

   // running light flasher and seed markers
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         flash_c   <= 1'b0;
         rl_edge_c <= 1'b0;
         rl_shot_c <= 1'b0;
         seed_c    <= 1'b0;
      end else if (scan_tick) begin
         flash_c   <= flash_done;
         rl_edge_c <= flash_c;
         rl_shot_c <= rl_shot;
         seed_c    <= img.run_mode && (seed_c || rel.run_light[0]);
      end
   end

   // relay outputs
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         rel <= RELAYS_RST;
      end else if (scan_tick) begin
         rel.toggle_relay <= rel.toggle_relay ^ tgl_rise;
         rel.delay_relay  <= dly_done;
         rel.count_relay  <= (next_cnt == CNT_PRESET);
         rel.store        <= next_store;
         rel.run_light    <= next_run;
         rel.stair_light  <= next_light;
      end
   end

   assign RELAYS_OUT = rel;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!ARST_N_IN);

   property p_toggle;
      scan_tick && tgl_rise |=> rel.toggle_relay != $past(rel.toggle_relay);
   endproperty
   a_toggle : assert property (p_toggle)
      else $error("toggle relay did not flip on press");

   property p_toggle_hold;
      !(scan_tick && tgl_rise) |=> $stable(rel.toggle_relay);
   endproperty
   a_toggle_hold : assert property (p_toggle_hold)
      else $error("toggle relay changed without press");

   property p_delay_on;
      $rose(rel.delay_relay) |-> dly_cnt == DELAY_A_TICKS;
   endproperty
   a_delay_on : assert property (p_delay_on)
      else $error("delay relay on before full delay");

   property p_delay_drop;
      scan_tick && !img.timer_trigger |=>
         !rel.delay_relay && dly_cnt == TMR_ZERO;
   endproperty
   a_delay_drop : assert property (p_delay_drop)
      else $error("delay relay held after trigger release");

   property p_cnt_step;
      scan_tick && !img.counter_clear |=>
         (cnt == $past(cnt)) || (cnt == $past(cnt) + 1'b1 && $past(cnt_rise));
   endproperty
   a_cnt_step : assert property (p_cnt_step)
      else $error("counter moved by other than one activation");

   property p_cnt_out;
      scan_tick |=> rel.count_relay == (cnt == CNT_PRESET);
   endproperty
   a_cnt_out : assert property (p_cnt_out)
      else $error("counter output does not match preset");

   property p_cnt_clear;
      scan_tick && img.counter_clear |=> cnt == CNT_ZERO && !rel.count_relay;
   endproperty
   a_cnt_clear : assert property (p_cnt_clear)
      else $error("counter clear ignored");

   property p_cnt_sat;
      cnt <= CNT_PRESET;
   endproperty
   a_cnt_sat : assert property (p_cnt_sat)
      else $error("counter passed preset");

   sequence s_detect;
      scan_tick && img.shift_btn && !edge_c;
   endsequence

   sequence s_pulse;
      scan_tick && shot_c && !img.shift_clear;
   endsequence

   property p_shot_lag;
      s_detect |=> shot_c && rel.store ==
         ($past(img.shift_clear) ? STORE_ZERO : $past(rel.store));
   endproperty
   a_shot_lag : assert property (p_shot_lag)
      else $error("pulse not seen in following scan");

   property p_shot_once;
      scan_tick && shot_c |=> !shot_c;
   endproperty
   a_shot_once : assert property (p_shot_once)
      else $error("shift pulse longer than one scan");

   property p_shift;
      s_pulse |=> rel.store[STORE_N-1:1] == $past(rel.store[STORE_N-2:0])
                  && rel.store[0] == $past(img.shift_value);
   endproperty
   a_shift : assert property (p_shift)
      else $error("shift chain did not move in order");

   property p_hold;
      !(scan_tick && (shot_c || img.shift_clear)) |=> $stable(rel.store);
   endproperty
   a_hold : assert property (p_hold)
      else $error("storage changed without pulse");

   property p_clear;
      scan_tick && img.shift_clear |=> rel.store == STORE_ZERO;
   endproperty
   a_clear : assert property (p_clear)
      else $error("shift clear did not win");

   property p_run_onehot;
      seed_c && img.run_mode |-> $onehot(rel.run_light);
   endproperty
   a_run_onehot : assert property (p_run_onehot)
      else $error("running light not one-hot");

   property p_stair_auto;
      scan_tick && auto_done |=> !rel.stair_light;
   endproperty
   a_stair_auto : assert property (p_stair_auto)
      else $error("stair light not switched off by timer");

   property p_stair_cont;
      cont_c |-> rel.stair_light;
   endproperty
   a_stair_cont : assert property (p_stair_cont)
      else $error("continuous mode with light off");

endmodule : scrf_top

// file: tb/scrf_panel.sv
// push-button panel model driving the relay block's input pins
`timescale 1ns/100ps
module scrf_panel (
   input  wire logic                 clk_in,   // controller clock
   input  wire scrf_pkg::scrf_pins_t req_in,   // wanted switch positions
   output scrf_pkg::scrf_pins_t      pins_out  // contacts as wired
);
   import scrf_pkg::*;

   // ****************************************
   // contact image
   // ****************************************
   // switches only move between the block's sampling edges
   always @(negedge clk_in) begin
      pins_out <= req_in;
   end

endmodule : scrf_panel

// file: tb/scrf_top_tb.sv
// self-checking bench for the scan-cycle relay block
`timescale 1ns/100ps
module scrf_top_tb;
   import scrf_pkg::*;

   // ****************************************
   // setup
   // ****************************************
   localparam int SD = 4;
   logic         clk_in      = 1'b0;
   logic         arst_n      = 1'b0;
   scrf_pins_t   req         = PINS_RST;
   scrf_pins_t   pins;
   scrf_relays_t rel;
   int           miscompares = 0;
   int           tests_run   = 0;

   always #5 clk_in = ~clk_in;

   scrf_panel i_scrf_panel (
      .clk_in   (clk_in),
      .req_in   (req),
      .pins_out (pins)
   );

   scrf_top #(
      .SCAN_DIV_P (SD),
      .AUTO_OFF_P (TMR_W'(50)),
      .LONG_OFF_P (TMR_W'(80))
   ) i_scrf_top (
      .CLK_IN     (clk_in),
      .ARST_N_IN  (arst_n),
      .PINS_IN    (pins),
      .RELAYS_OUT (rel)
   );

   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results

   task automatic scans(input int n);
      repeat (n * SD) @(negedge clk_in);
   endtask : scans

   task automatic cpress(input int n);
      repeat (n) begin
         req.count_btn <= 1'b1;
         scans(3);
         req.count_btn <= 1'b0;
         scans(3);
      end
   endtask : cpress

   task automatic spress(input int hi);
      req.stair_btn <= 1'b1;
      scans(hi);
      req.stair_btn <= 1'b0;
      scans(4);
   endtask : spress

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_toggle;
      req.toggle_btn <= 1'b1;
      scans(4);
      chk(4'(rel.toggle_relay), 4'h1);
      scans(6);
      chk(4'(rel.toggle_relay), 4'h1);
      req.toggle_btn <= 1'b0;
      scans(4);
      chk(4'(rel.toggle_relay), 4'h1);
      req.toggle_btn <= 1'b1;
      scans(4);
      chk(4'(rel.toggle_relay), 4'h0);
      req.toggle_btn <= 1'b0;
      scans(4);
   endtask : t_toggle

   task automatic t_delay;
      req.timer_trigger <= 1'b1;
      scans(990);
      chk(4'(rel.delay_relay), 4'h0);
      scans(20);
      chk(4'(rel.delay_relay), 4'h1);
      req.timer_trigger <= 1'b0;
      scans(4);
      chk(4'(rel.delay_relay), 4'h0);
      req.timer_trigger <= 1'b1;
      scans(500);
      chk(4'(rel.delay_relay), 4'h0);
      req.timer_trigger <= 1'b0;
      scans(4);
   endtask : t_delay

   task automatic t_counter;
      // a long press still counts once
      req.count_btn <= 1'b1;
      scans(20);
      req.count_btn <= 1'b0;
      scans(4);
      cpress(18);
      chk(4'(rel.count_relay), 4'h0);
      cpress(1);
      chk(4'(rel.count_relay), 4'h1);
      cpress(3);
      chk(4'(rel.count_relay), 4'h1);
      req.counter_clear <= 1'b1;
      scans(4);
      chk(4'(rel.count_relay), 4'h0);
      req.counter_clear <= 1'b0;
      scans(3);
      cpress(1);
      chk(4'(rel.count_relay), 4'h0);
   endtask : t_counter

   task automatic t_shift;
      logic       val [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
      logic [3:0] exp [5] = '{4'h1, 4'h2, 4'h4, 4'h9, 4'h2};
      logic [3:0] prev;
      prev = 4'h0;
      for (int i = 0; i < 5; i++) begin
         req.shift_value <= val[i];
         req.shift_btn   <= 1'b1;
         scans(2);
         chk(rel.store, prev);
         scans(6);
         chk(rel.store, exp[i]);
         req.shift_btn <= 1'b0;
         scans(4);
         chk(rel.store, exp[i]);
         prev = exp[i];
      end
      req.shift_value <= 1'b1;
      req.shift_btn   <= 1'b1;
      req.shift_clear <= 1'b1;
      scans(8);
      chk(rel.store, 4'h0);
      req.shift_btn   <= 1'b0;
      req.shift_clear <= 1'b0;
      req.shift_value <= 1'b0;
      scans(4);
   endtask : t_shift

   task automatic t_run;
      logic [3:0] seq [4] = '{4'h2, 4'h4, 4'h8, 4'h1};
      logic [3:0] prev;
      int         n;
      req.run_mode <= 1'b1;
      n = 0;
      while (rel.run_light === 4'h0 && n < 300) begin
         scans(1);
         n++;
      end
      chk(rel.run_light, 4'h1);
      prev = 4'h1;
      for (int k = 0; k < 4; k++) begin
         scans(90);
         chk(rel.run_light, prev);
         n = 0;
         while (rel.run_light === prev && n < 20) begin
            scans(1);
            n++;
         end
         chk(rel.run_light, seq[k]);
         prev = seq[k];
      end
      req.run_mode <= 1'b0;
      scans(4);
      chk(rel.run_light, 4'h0);
   endtask : t_run

   task automatic t_stair;
      spress(4);
      chk(4'(rel.stair_light), 4'h1);
      scans(32);
      chk(4'(rel.stair_light), 4'h1);
      scans(25);
      chk(4'(rel.stair_light), 4'h0);
      spress(4);
      chk(4'(rel.stair_light), 4'h1);
      spress(4);
      chk(4'(rel.stair_light), 4'h0);
      spress(220);
      chk(4'(rel.stair_light), 4'h1);
      scans(100);
      chk(4'(rel.stair_light), 4'h1);
      spress(4);
      chk(4'(rel.stair_light), 4'h0);
      req.stair_enhanced <= 1'b1;
      spress(220);
      scans(36);
      chk(4'(rel.stair_light), 4'h1);
      scans(50);
      chk(4'(rel.stair_light), 4'h0);
      req.stair_enhanced <= 1'b0;
   endtask : t_stair

   // ****************************************
   // sequence and watchdog
   // ****************************************
   initial begin
      repeat (3) @(negedge clk_in);
      arst_n = 1'b1;
      scans(2);
      chk(4'(rel != RELAYS_RST), 4'h0);
      t_toggle();
      t_delay();
      t_counter();
      t_shift();
      t_run();
      t_stair();
      results();
   end

   initial begin
      repeat (40000) @(posedge clk_in);
      chk(4'h0, 4'h1);
      results();
   end

endmodule : scrf_top_tb
